// ---- asa_params.svh ----
`ifndef ASA_PARAMS_SVH
`define ASA_PARAMS_SVH

// Delay chain geometry
`define ASA_TAPS 128
`define ASA_TAP_PS 45
`define ASA_CHAIN_PS 5760
`define ASA_MID_TAP 7'h40
`define ASA_FIXED_TAP 7'h40
`define ASA_LAST_TAP 127

// Window geometry: detect registers sit two taps (about 90 ps) apart
`define ASA_STEP_TAPS 2
`define ASA_STEP_PS 90
`define ASA_MAX_DET 4

// Same-side detections needed before a move
`define ASA_MOVE_HITS 3'h4
// Fast cycles with the valid output low after a move
`define ASA_HOLD_CYC 3'h4

// Register port
`define ASA_AW 2
`define ASA_DW 16
`define ASA_ADDR_CTRL 2'h0
`define ASA_ADDR_DELAY 2'h1
`define ASA_ADDR_STATUS 2'h2

// Control register fields
`define ASA_CTRL_MODE_LSB 0
`define ASA_CTRL_SIZE_LSB 2
`define ASA_CTRL_DDR_BIT 4
`define ASA_CTRL_FREEZE_BIT 5
`define ASA_CTRL_RATIO_LSB 6
`define ASA_CTRL_RESET 16'h0002
`define ASA_DELAY_RESET 7'h40

// Gearbox
`define ASA_WORD_W 8

`endif

// ---- asa_pkg.sv ----
package asa_pkg;

  // Delay source of the delay stage
  typedef enum logic [1:0] {
    ASA_MODE_FIXED,
    ASA_MODE_USER,
    ASA_MODE_ADAPT,
    ASA_MODE_SPARE
  } asa_mode_t;

  // Gearbox division ratio
  typedef enum logic [1:0] {
    ASA_GEAR_X1,
    ASA_GEAR_X2,
    ASA_GEAR_X4,
    ASA_GEAR_SPARE
  } asa_ratio_t;

  // Direction of the last window move
  typedef enum logic {
    ASA_DIR_LEFT,
    ASA_DIR_RIGHT
  } asa_dir_t;

endpackage

// ---- asa_gear_if.sv ----
interface asa_gear_if;
  import asa_pkg::*;
  logic bit_rise; // Centre sample, rising edge
  logic bit_fall; // Centre sample, falling edge
  logic ddr; // Double-rate capture
  asa_ratio_t ratio; // Division ratio
  logic [7:0] word; // Assembled word
  logic word_stb; // Word ready pulse

  modport src (output bit_rise, output bit_fall, output ddr, output ratio,
    input word, input word_stb);
  modport sink (input bit_rise, input bit_fall, input ddr, input ratio,
    output word, output word_stb);
endinterface

// ---- asa_gearbox.sv ----
`include "asa_params.svh"

module asa_gearbox
  import asa_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  asa_gear_if.sink gear
);

  logic [7:0] shift_reg; // Bits collected so far
  logic [7:0] shift_next;
  logic [3:0] cnt_reg; // Bits held in the shift register
  logic [3:0] cnt_next;
  logic [7:0] word_reg; // Last full word
  logic [7:0] word_next;
  logic stb_reg; // Word strobe
  logic stb_next;
  logic [3:0] need; // Bits per word for this ratio and rate
  logic [3:0] step; // Bits taken per cycle

  // Width per word: ratio times one or two bits per cycle
  always_comb begin
    unique case (gear.ratio)
      ASA_GEAR_X1: need = 4'h1;
      ASA_GEAR_X2: need = 4'h2;
      default: need = 4'h4;
    endcase
    step = gear.ddr ? 4'h2 : 4'h1;
    if (gear.ddr) begin
      need = {need[2:0], 1'b0};
    end
  end

  // Shift in the centre samples and emit a word when full
  always_comb begin
    stb_next = 1'b0;
    word_next = word_reg;
    if (gear.ddr) begin
      shift_next = {shift_reg[5:0], gear.bit_rise, gear.bit_fall};
    end else begin
      shift_next = {shift_reg[6:0], gear.bit_rise};
    end
    cnt_next = cnt_reg + step;
    if (cnt_next >= need) begin
      word_next = shift_next & ~(8'hFF << need);
      stb_next = 1'b1;
      cnt_next = 4'h0;
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      word_reg <= 8'h00;
      stb_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      word_reg <= word_next;
      stb_reg <= stb_next;
    end
  end

  assign gear.word = word_reg;
  assign gear.word_stb = stb_reg;

endmodule // asa_gearbox

// ---- asa_adaptive_sample_aligner.sv ----
// Functional notes
// - 128 taps of 45 ps, delayed copies
// - Fixed, programmed or adaptive delay modes
// - Centre register plus one to four detects
// - Neighbouring window registers two taps apart
// - Falling-edge window used in double rate
// - Only centre sample goes downstream
// - Window sized to the selected size
// - Freeze control holds window position in adaptive mode
// - Alignment starts at middle tap
// - Four same-side hits move window away
// - Fresh four hits needed after each move
// - Both-side hits still keep window moving
// - No transitions means no movement
// - Gearbox ratios x1, x2, x4, SDR/DDR
// - Valid low four cycles per move
// - Chain end returns window to middle
// - Four window sizes, set by the control size field
`include "asa_params.svh"

module asa_adaptive_sample_aligner
  import asa_pkg::*;
#(
  parameter int TAPS = `ASA_TAPS,
  parameter int MAX_DET = `ASA_MAX_DET
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic DATA_PIN,
  input wire logic [`ASA_AW-1:0] ADDR,
  input wire logic [`ASA_DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [`ASA_DW-1:0] RDATA,
  output logic [`ASA_WORD_W-1:0] RX_WORD,
  output logic RX_WORD_STB,
  output logic RX_BIT,
  output logic VALID
);

  // Pin synchroniser and delay chain
  logic s1_reg, s2_reg, s3_reg; // Three-stage pin capture
  logic din_reg; // Accepted pin level
  logic din_next;
  logic [TAPS-1:0] tap_reg; // Delayed copies, tap 0 least delayed
  logic [TAPS-1:0] tap_next;

  // Window registers, rising and falling edge sets
  logic ctr_reg, ctr_next; // Centre sample, rising edge
  logic ctrn_reg; // Centre sample, falling edge
  logic [MAX_DET:1] lft_reg, lft_next; // Detects on the less-delayed side
  logic [MAX_DET:1] rgt_reg, rgt_next; // Detects on the more-delayed side
  logic [MAX_DET:1] lftn_reg, rgtn_reg; // Falling-edge detects

  // Search state
  logic [6:0] pos_reg, pos_next; // Tap of the centre register
  logic [2:0] cnt_l_reg, cnt_l_next; // Consecutive left-side hits
  logic [2:0] cnt_r_reg, cnt_r_next; // Consecutive right-side hits
  asa_dir_t dir_reg, dir_next; // Direction of last move
  logic [2:0] hold_reg, hold_next; // Cycles left with valid low
  logic valid_reg, valid_next;
  logic adapt_reg, adapt_next; // Adaptive mode seen last cycle

  // Software registers
  logic [`ASA_DW-1:0] ctrl_reg, ctrl_next;
  logic [6:0] delay_reg, delay_next;
  logic [`ASA_DW-1:0] rdata_reg, rdata_next;

  // Decoded control fields
  asa_mode_t mode;
  asa_ratio_t ratio;
  logic [1:0] size;
  logic ddr;
  logic freeze;
  logic hit_l, hit_r; // Transition seen on each side this cycle

  // Gearbox link
  asa_gear_if gear ();

  // Pick one tap, reading zero outside the chain
  function automatic logic tap_pick(input logic [TAPS-1:0] line, input int idx);
    logic r;
    r = 1'b0;
    if (idx >= 0 && idx < TAPS) begin
      r = line[idx];
    end
    return r;
  endfunction

  // Any transition between neighbours from the centre outward
  function automatic logic side_hit(input logic ctr, input logic [MAX_DET:1] v,
    input logic [1:0] sel);
    logic h;
    logic prev;
    h = 1'b0;
    prev = ctr;
    for (int i = 1; i <= MAX_DET; i++) begin
      if (i <= int'(sel) + 1) begin
        if (v[i] != prev) begin
          h = 1'b1;
        end
        prev = v[i];
      end
    end
    return h;
  endfunction

  // Control field decode
  always_comb begin
    mode = asa_mode_t'(ctrl_reg[`ASA_CTRL_MODE_LSB +: 2]);
    size = ctrl_reg[`ASA_CTRL_SIZE_LSB +: 2];
    ddr = ctrl_reg[`ASA_CTRL_DDR_BIT];
    freeze = ctrl_reg[`ASA_CTRL_FREEZE_BIT];
    ratio = asa_ratio_t'(ctrl_reg[`ASA_CTRL_RATIO_LSB +: 2]);
  end

  // Accept the pin once stages two and three agree, then shift the chain
  always_comb begin
    din_next = (s2_reg == s3_reg) ? s3_reg : din_reg;
    tap_next = {tap_reg[TAPS-2:0], din_reg};
  end

  // Centre tap sample for the window
  always_comb begin
    ctr_next = tap_pick(tap_reg, int'(pos_reg));
  end

  // Detect taps spaced two elements apart on each side
  generate
    for (genvar g = 1; g <= MAX_DET; g++) begin : g_det
      always_comb begin
        lft_next[g] = tap_pick(tap_reg, int'(pos_reg) - `ASA_STEP_TAPS * g);
        rgt_next[g] = tap_pick(tap_reg, int'(pos_reg) + `ASA_STEP_TAPS * g);
      end
    end
  endgenerate

  // Transition detection, falling-edge set joins in double rate
  always_comb begin
    hit_l = side_hit(ctr_reg, lft_reg, size) | (ddr & side_hit(ctrn_reg, lftn_reg, size));
    hit_r = side_hit(ctr_reg, rgt_reg, size) | (ddr & side_hit(ctrn_reg, rgtn_reg, size));
  end

  // Window search and delay mode selection
  always_comb begin
    int half;
    int np;
    half = `ASA_STEP_TAPS * (int'(size) + 1);
    np = int'(pos_reg);
    pos_next = pos_reg;
    cnt_l_next = cnt_l_reg;
    cnt_r_next = cnt_r_reg;
    dir_next = dir_reg;
    adapt_next = 1'b0;
    unique case (mode)
      ASA_MODE_FIXED: begin
        pos_next = `ASA_FIXED_TAP;
        cnt_l_next = 3'h0;
        cnt_r_next = 3'h0;
      end
      ASA_MODE_USER: begin
        pos_next = delay_reg;
        cnt_l_next = 3'h0;
        cnt_r_next = 3'h0;
      end
      default: begin
        adapt_next = 1'b1;
        if (!adapt_reg) begin
          // Entering adaptive mode starts from the middle
          pos_next = `ASA_MID_TAP;
          cnt_l_next = 3'h0;
          cnt_r_next = 3'h0;
        end else if (freeze) begin
          // Frozen: position and counts stay put
          pos_next = pos_reg;
        end else begin
          // A hit on one side only breaks the other side's run
          if (hit_l) begin
            cnt_l_next = cnt_l_reg + 3'h1;
          end else if (hit_r) begin
            cnt_l_next = 3'h0;
          end
          if (hit_r) begin
            cnt_r_next = cnt_r_reg + 3'h1;
          end else if (hit_l) begin
            cnt_r_next = 3'h0;
          end
          // No hits leave counts and position unchanged
          if (cnt_l_next >= `ASA_MOVE_HITS && cnt_r_next >= `ASA_MOVE_HITS) begin
            // Both sides full: keep going the way we last went
            np = (dir_reg == ASA_DIR_RIGHT) ? np + `ASA_STEP_TAPS
              : np - `ASA_STEP_TAPS;
          end else if (cnt_l_next >= `ASA_MOVE_HITS) begin
            np = np + `ASA_STEP_TAPS;
            dir_next = ASA_DIR_RIGHT;
          end else if (cnt_r_next >= `ASA_MOVE_HITS) begin
            np = np - `ASA_STEP_TAPS;
            dir_next = ASA_DIR_LEFT;
          end
          if (np != int'(pos_reg)) begin
            cnt_l_next = 3'h0;
            cnt_r_next = 3'h0;
            if (np - half <= 0 || np + half >= `ASA_LAST_TAP) begin
              pos_next = `ASA_MID_TAP;
            end else begin
              pos_next = np[6:0];
            end
          end
        end
      end
    endcase
  end

  // Valid goes low for a fixed count after any window move
  always_comb begin
    hold_next = (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;
    if (pos_next != pos_reg) begin
      hold_next = `ASA_HOLD_CYC;
    end
    valid_next = (hold_next == 3'h0);
  end

  // Software writes and one-cycle-late reads
  always_comb begin
    ctrl_next = ctrl_reg;
    delay_next = delay_reg;
    rdata_next = rdata_reg;
    if (WR) begin
      unique case (ADDR)
        `ASA_ADDR_CTRL: ctrl_next = WDATA;
        `ASA_ADDR_DELAY: delay_next = WDATA[6:0];
        default: ; // Status and spare writes are dropped
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        `ASA_ADDR_CTRL: rdata_next = ctrl_reg;
        `ASA_ADDR_DELAY: rdata_next = {9'h000, delay_reg};
        `ASA_ADDR_STATUS: rdata_next = {1'b0, valid_reg, dir_reg, cnt_r_reg, cnt_l_reg, pos_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  // Rising-edge registers
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      din_reg <= 1'b0;
      tap_reg <= '0;
      ctr_reg <= 1'b0;
      lft_reg <= '0;
      rgt_reg <= '0;
      pos_reg <= `ASA_MID_TAP;
      cnt_l_reg <= 3'h0;
      cnt_r_reg <= 3'h0;
      dir_reg <= ASA_DIR_RIGHT;
      hold_reg <= 3'h0;
      valid_reg <= 1'b1;
      adapt_reg <= 1'b0;
      ctrl_reg <= `ASA_CTRL_RESET;
      delay_reg <= `ASA_DELAY_RESET;
      rdata_reg <= 16'h0000;
    end else begin
      s1_reg <= DATA_PIN;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      din_reg <= din_next;
      tap_reg <= tap_next;
      ctr_reg <= ctr_next;
      lft_reg <= lft_next;
      rgt_reg <= rgt_next;
      pos_reg <= pos_next;
      cnt_l_reg <= cnt_l_next;
      cnt_r_reg <= cnt_r_next;
      dir_reg <= dir_next;
      hold_reg <= hold_next;
      valid_reg <= valid_next;
      adapt_reg <= adapt_next;
      ctrl_reg <= ctrl_next;
      delay_reg <= delay_next;
      rdata_reg <= rdata_next;
    end
  end

  // Falling-edge duplicate window
  always_ff @(negedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctrn_reg <= 1'b0;
      lftn_reg <= '0;
      rgtn_reg <= '0;
    end else begin
      ctrn_reg <= ctr_next;
      lftn_reg <= lft_next;
      rgtn_reg <= rgt_next;
    end
  end

  // Only centre samples feed the gearbox
  assign gear.bit_rise = ctr_reg;
  assign gear.bit_fall = ctrn_reg;
  assign gear.ddr = ddr;
  assign gear.ratio = ratio;

  // Width converter
  asa_gearbox u_gear (
    .clk(CLOCK),
    .nrst(NRST),
    .gear(gear.sink)
  );

  // Outputs
  assign RDATA = rdata_reg;
  assign RX_WORD = gear.word;
  assign RX_WORD_STB = gear.word_stb;
  assign RX_BIT = ctr_reg;
  assign VALID = valid_reg;

endmodule // asa_adaptive_sample_aligner

// ---- asa_serial_tx.sv ----
module asa_serial_tx (
  input wire logic clk,
  input wire logic run,
  input wire logic level,
  input wire logic [7:0] half,
  output logic line = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // Cycles spent in the current bit
  logic [7:0] cnt_reg = 8'h00;
  // Idle holds a level; running toggles every half cycles
  always @(posedge clk) begin
    if (!run) begin
      line <= level;
      cnt_reg <= 8'h00;
    end else if (cnt_reg + 8'h01 >= half) begin
      line <= ~line;
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule // asa_serial_tx

// ---- asa_adaptive_sample_aligner_chk.sv ----
module asa_adaptive_sample_aligner_chk (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic DATA_PIN,
  input wire logic [1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic VALID
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  logic pin_reg, pin_next; // Last pin level
  logic [7:0] quiet_reg, quiet_next; // Cycles with no pin edge and no write
  logic frz_reg, frz_next; // Adaptive freeze written
  // Next values of the helper state
  always_comb begin
    pin_next = DATA_PIN;
    quiet_next = (quiet_reg == 8'hFF) ? quiet_reg : quiet_reg + 8'h01;
    frz_next = frz_reg;
    if (DATA_PIN != pin_reg || WR) begin
      quiet_next = 8'h00;
    end
    if (WR && ADDR == 2'h0) begin
      frz_next = WDATA[5] && WDATA[1];
    end
  end
  // Helper registers
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pin_reg <= 1'b0;
      quiet_reg <= 8'h00;
      frz_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      quiet_reg <= quiet_next;
      frz_reg <= frz_next;
    end
  end
  property p_valid_low;
    $fell(VALID) |-> !VALID [*4];
  endproperty
  a_valid_low: assert property (p_valid_low)
    else $error("VALID low run shorter than four cycles");
  property p_valid_rise;
    $rose(VALID) |-> !$past(VALID, 4);
  endproperty
  a_valid_rise: assert property (p_valid_rise)
    else $error("VALID rose before four low cycles");
  property p_rdata_hold;
    !RD |=> $stable(RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("RDATA changed without a read");
  property p_read_valid;
    RD && ADDR == 2'h2 |=> RDATA[14] == $past(VALID);
  endproperty
  a_read_valid: assert property (p_read_valid)
    else $error("Status valid bit differs from VALID");
  property p_counts;
    RD && ADDR == 2'h2 |=> RDATA[9:7] <= 3'h4 && RDATA[12:10] <= 3'h4;
  endproperty
  a_counts: assert property (p_counts)
    else $error("Side count above four");
  property p_unmapped;
    RD && ADDR == 2'h3 |=> RDATA == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped read not zero");
  property p_quiet;
    quiet_reg >= 8'h96 |-> !$fell(VALID);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("Window moved with no transitions");
  property p_freeze;
    frz_reg && $past(frz_reg, 2) |-> !$fell(VALID);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Window moved while frozen");
  c_move: cover property ($fell(VALID));
  c_status: cover property (RD && ADDR == 2'h2);
  c_freeze: cover property (frz_reg && !VALID);
endmodule // asa_adaptive_sample_aligner_chk

// ---- asa_adaptive_sample_aligner_bench.sv ----
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %s expected %0h seen %0h", nm, e, a); end end
module asa_adaptive_sample_aligner_bench
  import asa_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, pin, wr, rd, run, level, stb, rxbit, valid;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [7:0] word, half;
  logic [6:0] p1;
  int checks, miscompares, cyc, lows, stbs;
  // Device under test
  asa_adaptive_sample_aligner DUT (.CLOCK(clk), .NRST(nrst), .DATA_PIN(pin), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_WORD(word), .RX_WORD_STB(stb),
    .RX_BIT(rxbit), .VALID(valid));
  // Remote transmitter on the data pin; a single lane, so no lane realignment
  asa_serial_tx TX (.clk(clk), .run(run), .level(level), .half(half), .line(pin));
  // Register write, one strobe cycle
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Register read, data in the following cycle
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Counts low VALID cycles and word strobes over n cycles
  task automatic count(input int n);
    lows = 0;
    stbs = 0;
    repeat (n) begin
      #1;
      lows += (valid === 1'b0);
      stbs += (stb === 1'b1);
      @(posedge clk);
    end
  endtask
  // Final report and end of run
  task automatic conclude();
    $display("Checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Clock: one clock feeds chain and gearbox, so the word transfer never crosses
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  // Test sequence
  initial begin
    {nrst, wr, rd, run, level, addr, wdata, half} = '0;
    half = 8'h06;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(2'h0); `CHK("ctrl", 16'h0002, d)
    rd_reg(2'h1); `CHK("delay", 16'h0040, d)
    wr_reg(2'h3, 16'hFFFF);
    wr_reg(2'h2, 16'h0011);
    rd_reg(2'h3); `CHK("unmapped", 16'h0000, d)
    // Steady high line: no move, centre sample high
    level <= 1'b1;
    count(300); `CHK("quiet lows", 0, lows)
    rd_reg(2'h2); `CHK("start pos", 7'h40, d[6:0])
    `CHK("status valid", 1'b1, d[14])
    `CHK("centre bit", 1'b1, rxbit)
    // Programmed then fixed delay
    wr_reg(2'h1, 16'h0030);
    wr_reg(2'h0, 16'h0001);
    count(20); `CHK("user lows", 4, lows)
    rd_reg(2'h2); `CHK("user pos", 7'h30, d[6:0])
    wr_reg(2'h0, 16'h0000);
    count(20); `CHK("fixed lows", 4, lows)
    rd_reg(2'h2); `CHK("fixed pos", 7'h40, d[6:0])
    level <= 1'b0;
    count(200); `CHK("centre bit", 1'b0, rxbit)
    // Every window size is accepted
    for (int s = 0; s < 4; s++) begin
      wr_reg(2'h0, 16'(s << 2));
      rd_reg(2'h0); `CHK("size", 16'(s << 2), d)
    end
    // Word strobe rate for every ratio; double rate doubles both bits per cycle
    // and bits per word, so the rate depends on the ratio only
    for (int r = 0; r < 4; r++) begin
      for (int q = 0; q < 2; q++) begin
        wr_reg(2'h0, 16'((r << 6) | (q << 4)));
        count(64);
        p1 = 7'(64 / ((r == 0) ? 1 : (r == 1) ? 2 : 4));
        `CHK("strobes", 1'b1, stbs >= p1 - 1 && stbs <= p1 + 1)
      end
    end
    // Steady high line fills only the used bits of the word
    level <= 1'b1;
    wr_reg(2'h0, 16'h0080);
    count(200); `CHK("word x4", 8'h0F, word)
    wr_reg(2'h0, 16'h0090);
    count(20); `CHK("word x4 ddr", 8'hFF, word)
    // Adaptive search on a toggling line, largest window
    run <= 1'b1;
    wr_reg(2'h0, 16'h000E);
    count(3000); `CHK("moved", 1'b1, lows >= 4)
    rd_reg(2'h2); `CHK("pos even", 1'b0, d[0])
    `CHK("pos inside", 1'b1, d[6:0] > 7'h08 && d[6:0] < 7'h77)
    // Frozen window holds while traffic runs
    wr_reg(2'h0, 16'h002E);
    count(10);
    rd_reg(2'h2);
    p1 = d[6:0];
    count(500); `CHK("frozen lows", 0, lows)
    rd_reg(2'h2); `CHK("frozen pos", p1, d[6:0])
    // Line stops: adaptive window stays put
    run <= 1'b0;
    count(300);
    // Reserved mode code also selects adaptive steering
    wr_reg(2'h0, 16'h000F);
    rd_reg(2'h2);
    p1 = d[6:0];
    count(300); `CHK("still lows", 0, lows)
    rd_reg(2'h2); `CHK("still pos", p1, d[6:0])
    conclude();
  end
endmodule // asa_adaptive_sample_aligner_bench
bind asa_adaptive_sample_aligner asa_adaptive_sample_aligner_chk u_chk (.CLOCK(CLOCK),
  .NRST(NRST), .DATA_PIN(DATA_PIN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .VALID(VALID));
